/* File: por_routing.sv */
// top: output relay routing for an overvoltage/undervoltage protection relay
// Operation
// - relay A always follows the overvoltage trip
// - relay B always follows the undervoltage trip
// - switch 1 set applies external blocking to undervoltage stage; default set
// - relay D from undervoltage start, overvoltage start, undervoltage trip per switches 2-4
// - relay C from undervoltage trip (switch 5), overvoltage trip (switch 7)
// - relay A also from undervoltage trip (6), relay B from overvoltage trip (8)
// - fault alarm holds normally-closed path when healthy, changes over on fault
// - trip signalling output on either stage trip
// - start signalling output on undervoltage trip or either stage start
// - stage starts on limit crossing, trips after operate time still started
`timescale 1ns/1ps
module por_routing
    import por_pkg::*;
#(
    parameter int OV_OPERATE_CYCLES = OV_CYCLES,
    parameter int UV_OPERATE_CYCLES = UV_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // stage limit comparators, asynchronous to clk_i
    input wire logic ov_limit_i,
    input wire logic uv_limit_i,
    // external blocking control input pin
    input wire logic blocking_control_input_i,
    // front-panel routing switches, bit 0 is switch 1
    input wire logic [NUM_SW-1:0] output_routing_switches_i,
    // self-supervision fault detected
    input wire logic internal_fault_i,
    // output relay drives
    output por_relays_t relays_o,
    // signalling outputs
    output logic trip_signalling_output_o,
    output logic start_signalling_output_o,
    // changeover alarm contact: nc path closed when healthy
    output logic internal_fault_alarm_nc_o,
    output logic internal_fault_alarm_no_o
);
    // synchroniser pairs: only the second flop of each is read
    logic [1:0] ov_sync_ff;
    logic [1:0] uv_sync_ff;
    logic [1:0] blk_sync_ff;
    logic [1:0] flt_sync_ff;
    logic [NUM_SW-1:0] sw_s1_ff;
    logic [NUM_SW-1:0] sw_ff;

    // alarm state
    logic healthy_ff;
    logic nxt_healthy;

    // clean levels after the synchronisers
    wire logic ov_limit;
    wire logic uv_limit;
    wire logic blk_level;
    wire logic fault_level;

    // one enable per routing switch
    wire logic en_block;
    wire logic en_uvs_to_d;
    wire logic en_ovs_to_d;
    wire logic en_uvt_to_d;
    wire logic en_uvt_to_c;
    wire logic en_uvt_to_a;
    wire logic en_ovt_to_c;
    wire logic en_ovt_to_b;

    // stage outputs and their plain wires
    por_stage_t ov_stage;
    por_stage_t uv_stage;
    wire logic ov_start;
    wire logic ov_trip;
    wire logic uv_start;
    wire logic uv_trip;
    wire logic uv_block;

    // routed terms, one per switch-enabled path
    wire logic uvs_to_d;
    wire logic ovs_to_d;
    wire logic uvt_to_d;
    wire logic uvt_to_c;
    wire logic uvt_to_a;
    wire logic ovt_to_c;
    wire logic ovt_to_b;

    // drives before they reach the ports
    wire logic drive_a;
    wire logic drive_b;
    wire logic drive_c;
    wire logic drive_d;
    wire logic any_trip;
    wire logic any_start;

    // comparator pins are asynchronous to clk_i
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ov_sync_ff <= 2'h0;
        end else begin
            ov_sync_ff <= {ov_sync_ff[0], ov_limit_i};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uv_sync_ff <= 2'h0;
        end else begin
            uv_sync_ff <= {uv_sync_ff[0], uv_limit_i};
        end
    end

    // the external blocking pin
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blk_sync_ff <= 2'h0;
        end else begin
            blk_sync_ff <= {blk_sync_ff[0], blocking_control_input_i};
        end
    end

    // fault sync leaves reset in the fault state so the alarm starts faulted
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flt_sync_ff <= 2'h3;
        end else begin
            flt_sync_ff <= {flt_sync_ff[0], internal_fault_i};
        end
    end

    // switches are slow front-panel levels, synchronised like any pin
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_s1_ff <= SW_DEFAULT;
        end else begin
            sw_s1_ff <= output_routing_switches_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_ff <= SW_DEFAULT;
        end else begin
            sw_ff <= sw_s1_ff;
        end
    end

    assign ov_limit = ov_sync_ff[1];
    assign uv_limit = uv_sync_ff[1];
    assign blk_level = blk_sync_ff[1];
    assign fault_level = flt_sync_ff[1];

    assign en_block = sw_ff[SW_BLOCK];
    assign en_uvs_to_d = sw_ff[SW_UVS_TO_D];
    assign en_ovs_to_d = sw_ff[SW_OVS_TO_D];
    assign en_uvt_to_d = sw_ff[SW_UVT_TO_D];
    assign en_uvt_to_c = sw_ff[SW_UVT_TO_C];
    assign en_uvt_to_a = sw_ff[SW_UVT_TO_A];
    assign en_ovt_to_c = sw_ff[SW_OVT_TO_C];
    assign en_ovt_to_b = sw_ff[SW_OVT_TO_B];

    // blocking only reaches the undervoltage stage when switch 1 is set
    assign uv_block = en_block & blk_level;

    // the overvoltage stage has no blocking path
    por_stage #(.OPERATE_CYCLES(OV_OPERATE_CYCLES)) u_ov (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .limit_i(ov_limit),
        .inhibit_i(1'b0),
        .stage_o(ov_stage)
    );

    por_stage #(.OPERATE_CYCLES(UV_OPERATE_CYCLES)) u_uv (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .limit_i(uv_limit),
        .inhibit_i(uv_block),
        .stage_o(uv_stage)
    );

    assign ov_start = ov_stage.start;
    assign ov_trip = ov_stage.trip;
    assign uv_start = uv_stage.start;
    assign uv_trip = uv_stage.trip;

    // routed terms
    assign uvs_to_d = en_uvs_to_d & uv_start;
    assign ovs_to_d = en_ovs_to_d & ov_start;
    assign uvt_to_d = en_uvt_to_d & uv_trip;
    assign uvt_to_c = en_uvt_to_c & uv_trip;
    assign ovt_to_c = en_ovt_to_c & ov_trip;
    assign uvt_to_a = en_uvt_to_a & uv_trip;
    assign ovt_to_b = en_ovt_to_b & ov_trip;

    // relay drives are pure OR of sources so no extra latency is added
    assign drive_a = ov_trip | uvt_to_a;
    assign drive_b = uv_trip | ovt_to_b;
    assign drive_c = uvt_to_c | ovt_to_c;
    assign drive_d = uvs_to_d | ovs_to_d | uvt_to_d;
    assign any_trip = ov_trip | uv_trip;
    assign any_start = uv_trip | ov_start | uv_start;

    // a trip holds only while its limit holds; nothing latches here
    assign relays_o.relay_a = drive_a;
    assign relays_o.relay_b = drive_b;
    assign relays_o.relay_c = drive_c;
    assign relays_o.relay_d = drive_d;
    assign trip_signalling_output_o = any_trip;
    assign start_signalling_output_o = any_start;

    // fail-safe: unhealthy while in reset, so loss of power reads as fault
    assign nxt_healthy = !fault_level;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            healthy_ff <= 1'b0;
        end else begin
            healthy_ff <= nxt_healthy;
        end
    end

    assign internal_fault_alarm_nc_o = healthy_ff;
    assign internal_fault_alarm_no_o = !healthy_ff;
endmodule

/* File: por_pkg.sv */
// package: constants and carrier types for the protection output routing block
package por_pkg;
    localparam int NUM_SW = 8;
    // factory default of the routing switches: all set
    localparam logic [7:0] SW_DEFAULT = 8'hff;
    // switch positions
    localparam int SW_BLOCK = 0;
    localparam int SW_UVS_TO_D = 1;
    localparam int SW_OVS_TO_D = 2;
    localparam int SW_UVT_TO_D = 3;
    localparam int SW_UVT_TO_C = 4;
    localparam int SW_UVT_TO_A = 5;
    localparam int SW_OVT_TO_C = 6;
    localparam int SW_OVT_TO_B = 7;
    // operate times in microseconds, and clock rate
    localparam int CLK_MHZ = 125;
    localparam int OV_TIME_US = 100;
    localparam int UV_TIME_US = 100;
    localparam int OV_CYCLES = OV_TIME_US * CLK_MHZ;
    localparam int UV_CYCLES = UV_TIME_US * CLK_MHZ;
    localparam int CNT_W = 32;

    typedef struct packed {
        logic start;
        logic trip;
    } por_stage_t;

    typedef struct packed {
        logic relay_a;
        logic relay_b;
        logic relay_c;
        logic relay_d;
    } por_relays_t;
endpackage

/* File: por_stage.sv */
// one protection stage: start on limit crossing, trip after operate time
`timescale 1ns/1ps
module por_stage
    import por_pkg::*;
#(
    parameter int OPERATE_CYCLES = 12500
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // limit crossed, already synchronised
    input wire logic limit_i,
    // trip inhibit
    input wire logic inhibit_i,
    // stage outputs
    output por_stage_t stage_o
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic trip_ff;
    logic nxt_trip;
    wire logic elapsed = (cnt_ff >= CNT_W'(OPERATE_CYCLES - 1));

    // counter restarts whenever the start condition drops
    assign nxt_cnt = !limit_i ? '0 : (elapsed ? cnt_ff : cnt_ff + CNT_W'(1));
    assign nxt_trip = limit_i && elapsed && !inhibit_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
            trip_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            trip_ff <= nxt_trip;
        end
    end

    assign stage_o.start = limit_i;
    assign stage_o.trip = trip_ff;
endmodule

/* File: por_breaker.sv */
// far-side model: circuit breaker tripped by output relay a or b
`timescale 1ns/1ps
module por_breaker
    import por_pkg::*;
(
    // clock and relay contacts
    input wire logic clk_i,
    input wire por_relays_t relays_i,
    // breaker state
    output logic open_o
);
    // the mechanism lags the contact by one edge, so a relay must hold its drive
    always_ff @(posedge clk_i) open_o <= relays_i.relay_a | relays_i.relay_b;
endmodule

/* File: por_routing_sva.sv */
// checker: port-level properties of the output routing block
`timescale 1ns/1ps
module por_routing_sva
    import por_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // inputs
    input wire logic ov_limit_i,
    input wire logic uv_limit_i,
    input wire logic blocking_control_input_i,
    input wire logic [NUM_SW-1:0] output_routing_switches_i,
    input wire logic internal_fault_i,
    // outputs
    input wire por_relays_t relays_o,
    input wire logic trip_signalling_output_o,
    input wire logic start_signalling_output_o,
    input wire logic internal_fault_alarm_nc_o,
    input wire logic internal_fault_alarm_no_o
);
    wire tr = trip_signalling_output_o;
    wire nc = internal_fault_alarm_nc_o;
    wire [7:0] sw = output_routing_switches_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // switches reach the relays two edges late through their syncing flops
    property p_quiet;
        !tr |-> !(relays_o.relay_a | relays_o.relay_b | relays_o.relay_c);
    endproperty
    a_quiet: assert property (p_quiet) else $error("relay on without trip");
    property p_ab; tr && $past(sw[5], 2) && $past(sw[7], 2) |-> relays_o[3:2] == 2'h3; endproperty
    a_ab: assert property (p_ab) else $error("relay a or b missed");
    property p_c; tr && $past(sw[4], 2) && $past(sw[6], 2) |-> relays_o.relay_c; endproperty
    a_c: assert property (p_c) else $error("relay c missed");
    property p_d; &$past(sw[3:1], 2) |-> relays_o.relay_d == start_signalling_output_o; endproperty
    a_d: assert property (p_d) else $error("relay d wrong");
    property p_flt; internal_fault_i [*3] |=> !nc && internal_fault_alarm_no_o; endproperty
    a_flt: assert property (p_flt) else $error("alarm not changed over");
    // four edges, one more than the three flops of the fault path need
    property p_ok; !internal_fault_i [*4] |=> nc && !internal_fault_alarm_no_o; endproperty
    a_ok: assert property (p_ok) else $error("alarm not healthy");
    // eight edges assume an operate count of 4 at the instance
    property p_ovt; ov_limit_i [*8] |=> tr; endproperty
    a_ovt: assert property (p_ovt) else $error("no overvoltage trip");
    property p_blk; (sw[0] && blocking_control_input_i && !ov_limit_i) [*4] |=> !tr; endproperty
    a_blk: assert property (p_blk) else $error("blocked trip seen");
    property p_cause; tr |-> $past(ov_limit_i, 3) || $past(uv_limit_i, 3); endproperty
    a_cause: assert property (p_cause) else $error("trip without limit");
endmodule
bind por_routing por_routing_sva u_sva (.*);

/* File: tb.sv */
// testbench: routing, blocking and alarm scenarios for the output routing block
`timescale 1ns/1ps
module tb;
    import por_pkg::*;
    logic clk_i = 0, rst_n_i = 0, ov_limit_i = 0, uv_limit_i = 0;
    logic blocking_control_input_i = 0, internal_fault_i = 0, brk;
    logic [7:0] output_routing_switches_i = SW_DEFAULT;
    por_relays_t relays_o;
    logic trip_signalling_output_o, start_signalling_output_o;
    logic internal_fault_alarm_nc_o, internal_fault_alarm_no_o;
    int err_count = 0, check_count = 0, cyc = 0;
    initial forever #4 clk_i = ~clk_i;
    // short operate counts keep each trip within a dozen cycles
    por_routing #(.OV_OPERATE_CYCLES(4), .UV_OPERATE_CYCLES(4)) DUT (.*);
    por_breaker brk_m (.clk_i(clk_i), .relays_i(relays_o), .open_o(brk));
    wire logic [6:0] outs = {relays_o, trip_signalling_output_o, start_signalling_output_o, brk};
    task chk(input logic [6:0] got, input logic [6:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apply(input logic [7:0] s, input logic o, u, b, input logic [5:0] e);
        @(negedge clk_i);
        {output_routing_switches_i, ov_limit_i} = {s, o};
        {uv_limit_i, blocking_control_input_i} = {u, b};
        repeat (12) @(negedge clk_i);
        chk(outs, {e, e[5] | e[4]});
        {ov_limit_i, uv_limit_i} = 2'h0;
        repeat (6) @(negedge clk_i);
        chk(outs, 7'h00);
    endtask
    task t_fixed;
        apply(8'h00, 1, 0, 0, 6'h23);
        apply(8'h00, 0, 1, 0, 6'h13);
    endtask
    task t_switches;
        apply(8'hff, 1, 0, 0, 6'h3f);
        apply(8'h84, 1, 0, 0, 6'h37);
        apply(8'h42, 0, 1, 0, 6'h17);
        apply(8'h18, 0, 1, 0, 6'h1f);
        apply(8'h40, 1, 0, 0, 6'h2b);
        apply(8'h20, 0, 1, 0, 6'h33);
    endtask
    task t_block;
        apply(8'hff, 0, 1, 1, 6'h05);
        apply(8'hfe, 0, 1, 1, 6'h3f);
    endtask
    task t_alarm;
        chk({5'h00, internal_fault_alarm_nc_o, internal_fault_alarm_no_o}, 7'h02);
        internal_fault_i = 1;
        repeat (4) @(negedge clk_i);
        chk({5'h00, internal_fault_alarm_nc_o, internal_fault_alarm_no_o}, 7'h01);
        internal_fault_i = 0;
        repeat (5) @(negedge clk_i);
        chk({5'h00, internal_fault_alarm_nc_o, internal_fault_alarm_no_o}, 7'h02);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        chk({5'h00, internal_fault_alarm_nc_o, internal_fault_alarm_no_o}, 7'h01);
        rst_n_i = 1;
        t_fixed;
        t_switches;
        t_block;
        t_alarm;
        give_verdict;
    end
endmodule
